// ==== core/mifdec_regs.vh ====
// Constants for the memory interface decode and arbitration block.
// Assumes inclusion by bare name from the core files.
`ifndef MIFDEC_REGS_VH
`define MIFDEC_REGS_VH
`define MIFDEC_OFS_BUF_RAM_BASE 12'h290
`define MIFDEC_OFS_BUF_SEGMENT 12'h291
`define MIFDEC_OFS_TIMING_LOW 12'h292
`define MIFDEC_OFS_TIMING_HIGH 12'h294
`define MIFDEC_SFR_IFC_CONTROL 12'h495
`define MIFDEC_SFR_WIN_BASE_LOW 12'h496
`define MIFDEC_SFR_WIN_BASE_HIGH 12'h497
`define MIFDEC_RST_BUF_RAM_BASE 8'hFE
`define MIFDEC_RST_BUF_SEGMENT 8'hFF
`define MIFDEC_RST_TIMING_LOW 8'hEF
`define MIFDEC_RST_TIMING_HIGH 8'hFF
`define MIFDEC_RST_IFC_CONTROL 8'h00
`define MIFDEC_RST_WIN_BASE_LOW 8'hF0
`define MIFDEC_RST_WIN_BASE_HIGH 8'h0F
`define MIFDEC_BIT_WIN_ENABLE 0
`define MIFDEC_BIT_RAM_ENABLE 0
`define MIFDEC_BIT_WAIT_DISABLE 4
`define MIFDEC_BIT_EXT_DISABLE 3
`define MIFDEC_OBJ_REG_LAST 12'h1FF
`define MIFDEC_EXT_ADDR_HIGH 19
`endif

// ==== core/mifdec_arbiter.v ====
// Alternating two-requester bus arbiter with burst lock.
// Assumes requests are held until granted and done pulses once per access.
`include "mifdec_regs.vh"
module mifdec_arbiter (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Requests
  input wire core_req_in,
  input wire core_burst_in,
  input wire dma_req_in,
  input wire done_in,
  // Grants
  output wire core_gnt_out,
  output wire dma_gnt_out,
  output wire busy_out
);
  reg busy;
  reg owner_dma;
  reg last_dma;
  reg burst_lock;
  wire pick_dma;
  // Alternate: the requester that did not go last wins a tie.
  assign pick_dma = dma_req_in && !burst_lock && (!core_req_in || !last_dma);
  assign core_gnt_out = busy && !owner_dma;
  assign dma_gnt_out = busy && owner_dma;
  assign busy_out = busy;
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy <= 1'b0;
      owner_dma <= 1'b0;
      last_dma <= 1'b0;
      burst_lock <= 1'b0;
    end
    else if (!busy)
    begin
      if (pick_dma || core_req_in)
      begin
        busy <= 1'b1;
        owner_dma <= pick_dma;
      end
    end
    else if (done_in)
    begin
      busy <= 1'b0;
      last_dma <= owner_dma;
      // A core burst keeps the DMA out until its final access ends.
      burst_lock <= !owner_dma && core_burst_in;
    end
  end
endmodule // mifdec_arbiter

// ==== core/mifdec_timer.v ====
// External cycle sequencer driven by a one-bit ALE field and two-bit strobe and hold fields.
// Assumes start pulses only while idle; counts are in system clocks.
`include "mifdec_regs.vh"
module mifdec_timer (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Control
  input wire start_in,
  input wire write_in,
  input wire wait_enable_in,
  input wire ext_wait_in,
  input wire [7:0] timing_low_in,
  input wire [7:0] timing_high_in,
  // Strobes
  output reg ale_out,
  output reg rd_n_out,
  output reg wr_n_out,
  output wire done_out
);
  localparam S_IDLE = 4'b0001;
  localparam S_ALE = 4'b0010;
  localparam S_STROBE = 4'b0100;
  localparam S_HOLD = 4'b1000;
  reg [3:0] state;
  reg [2:0] cnt;
  wire [2:0] ale_len;
  wire [2:0] strobe_len;
  wire [2:0] hold_len;
  assign ale_len = {2'b00, timing_low_in[5]} + 3'h1;
  assign strobe_len = write_in ? {1'b0, timing_high_in[7:6]} + 3'h1
                               : {1'b0, timing_high_in[3:2]} + 3'h1;
  assign hold_len = write_in ? {1'b0, timing_high_in[5:4]} + 3'h1
                             : {1'b0, timing_low_in[3:2]} + 3'h1;
  assign done_out = (state == S_HOLD) && (cnt == 3'h1);
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= S_IDLE;
      cnt <= 3'h0;
      ale_out <= 1'b0;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (start_in)
          begin
            state <= S_ALE;
            cnt <= ale_len;
            ale_out <= 1'b1;
          end
        end
        S_ALE:
        begin
          if (cnt == 3'h1)
          begin
            state <= S_STROBE;
            cnt <= strobe_len;
            ale_out <= 1'b0;
            rd_n_out <= write_in;
            wr_n_out <= !write_in;
          end
          else
            cnt <= cnt - 3'h1;
        end
        S_STROBE:
        begin
          // The wait input stretches the strobe only when waits are enabled.
          if (cnt == 3'h1 && !(wait_enable_in && ext_wait_in))
          begin
            state <= S_HOLD;
            cnt <= hold_len;
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
          end
          else if (cnt != 3'h1)
            cnt <= cnt - 3'h1;
        end
        S_HOLD:
        begin
          if (cnt == 3'h1)
            state <= S_IDLE;
          else
            cnt <= cnt - 3'h1;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // mifdec_timer

// ==== core/mifdec_top.v ====
// Memory interface: address decode to register window, buffer RAM or the
// external 16-bit bus, with core/DMA arbitration and programmable timing.
// Assumes requesters hold address and request until their done pulse, and
// that the register window's own slaves answer in one cycle.
`include "mifdec_regs.vh"
// Behaviour
// - Core address top twelve bits equal window base high and low[7:4]: register bus.
// - Window starts on a 4K boundary; low twelve bits are the offset.
// - Window base registers reset to 0Fh high and F0h low.
// - Window enable is base-low bit 0, resets to 0, gates window routing.
// - Window offsets 000h to 1FFh hold eight registers per object, 32 objects.
// - Core or DMA top fifteen bits equal segment and base[7:1]: buffer RAM.
// - Buffer RAM enable resets to 0; setting it enables buffer RAM decode.
// - Every DMA buffer access takes its top eight address bits from segment.
// - Control bit 4 disables wait states, bit 3 disables external access.
// - Arbitration alternates between core and DMA when both request.
// - DMA is not granted during a core burst until the burst completes.
// - External data bus is fixed at 16 bits, no dynamic sizing.
module mifdec_top (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Core request
  input wire core_req_in,
  input wire core_burst_in,
  input wire core_write_in,
  input wire [23:0] core_addr_in,
  input wire [15:0] core_wdata_in,
  output wire core_done_out,
  output reg [15:0] core_rdata_out,
  output wire core_fault_out,
  // DMA request, 16-bit offset within the buffer segment
  input wire dma_req_in,
  input wire dma_write_in,
  input wire [15:0] dma_addr_in,
  input wire [15:0] dma_wdata_in,
  output wire dma_done_out,
  output reg [15:0] dma_rdata_out,
  output wire dma_fault_out,
  // Special function register port
  input wire sfr_wr_in,
  input wire [11:0] sfr_addr_in,
  input wire [7:0] sfr_wdata_in,
  output reg [7:0] sfr_rdata_out,
  // Register window bus
  output reg win_sel_out,
  output reg win_write_out,
  output reg [11:0] win_offset_out,
  output reg [15:0] win_wdata_out,
  output wire win_obj_out,
  input wire [15:0] win_rdata_in,
  // External memory bus
  output reg [`MIFDEC_EXT_ADDR_HIGH:1] ext_addr_out,
  input wire [15:0] ext_data_in,
  output reg [15:0] ext_data_out,
  output reg ext_data_oe_n_out,
  output wire ext_ale_out,
  output wire ext_rd_n_out,
  output wire ext_wr_n_out,
  input wire ext_wait_in
);
  parameter RAM_WORDS = 256;
  localparam A_IDLE = 4'b0001;
  localparam A_LOCAL = 4'b0010;
  localparam A_EXT = 4'b0100;
  localparam A_DONE = 4'b1000;
  reg [7:0] buf_ram_base;
  reg [7:0] buf_segment;
  reg [7:0] timing_low;
  reg [7:0] timing_high;
  reg [7:0] ifc_control;
  reg [7:0] win_base_low;
  reg [7:0] win_base_high;
  reg [15:0] ram [0:RAM_WORDS-1];
  reg [3:0] state;
  reg fault;
  reg [15:0] rdata;
  reg wait_sync_a;
  reg wait_sync_b;
  wire core_gnt;
  wire dma_gnt;
  wire busy;
  wire cyc_done;
  wire ext_done;
  wire ext_start;
  wire [23:0] addr;
  wire [15:0] wdata;
  wire write;
  wire hit_win;
  wire hit_ram;
  wire ext_off;
  // Word-addressed regions from a full byte address; shared by core and DMA.
  function [1:0] region;
    input [23:0] a;
    input [7:0] wbh;
    input [7:0] wbl;
    input [7:0] seg;
    input [7:0] rb;
    input is_dma;
    begin
      region[1] = !is_dma && wbl[`MIFDEC_BIT_WIN_ENABLE]
                  && (a[23:12] == {wbh, wbl[7:4]});
      region[0] = rb[`MIFDEC_BIT_RAM_ENABLE] && (a[23:9] == {seg, rb[7:1]});
    end
  endfunction
  assign addr = dma_gnt ? {buf_segment, dma_addr_in} : core_addr_in;
  assign wdata = dma_gnt ? dma_wdata_in : core_wdata_in;
  assign write = dma_gnt ? dma_write_in : core_write_in;
  assign {hit_win, hit_ram} = region(addr, win_base_high, win_base_low,
                                     buf_segment, buf_ram_base, dma_gnt);
  assign ext_off = ifc_control[`MIFDEC_BIT_EXT_DISABLE];
  assign ext_start = (state == A_IDLE) && busy && !hit_win && !hit_ram && !ext_off;
  assign cyc_done = (state == A_DONE);
  assign core_done_out = cyc_done && core_gnt;
  assign dma_done_out = cyc_done && dma_gnt;
  assign core_fault_out = core_done_out && fault;
  assign dma_fault_out = dma_done_out && fault;
  assign win_obj_out = win_sel_out && (win_offset_out <= `MIFDEC_OBJ_REG_LAST);
  mifdec_arbiter u_arb (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .core_req_in(core_req_in),
    .core_burst_in(core_burst_in),
    .dma_req_in(dma_req_in),
    .done_in(cyc_done),
    .core_gnt_out(core_gnt),
    .dma_gnt_out(dma_gnt),
    .busy_out(busy)
  );
  mifdec_timer u_tim (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(ext_start),
    .write_in(write),
    .wait_enable_in(!ifc_control[`MIFDEC_BIT_WAIT_DISABLE]),
    .ext_wait_in(wait_sync_b),
    .timing_low_in(timing_low),
    .timing_high_in(timing_high),
    .ale_out(ext_ale_out),
    .rd_n_out(ext_rd_n_out),
    .wr_n_out(ext_wr_n_out),
    .done_out(ext_done)
  );
  // Special function registers and the local configuration registers.
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ifc_control <= `MIFDEC_RST_IFC_CONTROL;
      win_base_low <= `MIFDEC_RST_WIN_BASE_LOW;
      win_base_high <= `MIFDEC_RST_WIN_BASE_HIGH;
      buf_ram_base <= `MIFDEC_RST_BUF_RAM_BASE;
      buf_segment <= `MIFDEC_RST_BUF_SEGMENT;
      timing_low <= `MIFDEC_RST_TIMING_LOW;
      timing_high <= `MIFDEC_RST_TIMING_HIGH;
    end
    else
    begin
      if (sfr_wr_in)
      begin
        case (sfr_addr_in)
          `MIFDEC_SFR_IFC_CONTROL: ifc_control <= sfr_wdata_in;
          `MIFDEC_SFR_WIN_BASE_LOW: win_base_low <= sfr_wdata_in;
          `MIFDEC_SFR_WIN_BASE_HIGH: win_base_high <= sfr_wdata_in;
          default: ;
        endcase
      end
      // The window's own configuration words are written through the window.
      if (state == A_IDLE && busy && hit_win && write)
      begin
        case (addr[11:0])
          `MIFDEC_OFS_BUF_RAM_BASE: buf_ram_base <= wdata[7:0];
          `MIFDEC_OFS_BUF_SEGMENT: buf_segment <= wdata[15:8];
          `MIFDEC_OFS_TIMING_LOW: timing_low <= wdata[7:0];
          `MIFDEC_OFS_TIMING_HIGH: timing_high <= wdata[7:0];
          default: ;
        endcase
      end
    end
  end
  always @*
  begin
    case (sfr_addr_in)
      `MIFDEC_SFR_IFC_CONTROL: sfr_rdata_out = ifc_control;
      `MIFDEC_SFR_WIN_BASE_LOW: sfr_rdata_out = win_base_low;
      `MIFDEC_SFR_WIN_BASE_HIGH: sfr_rdata_out = win_base_high;
      default: sfr_rdata_out = 8'h00;
    endcase
  end
  // The wait pin is asynchronous to the system clock.
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wait_sync_a <= 1'b0;
      wait_sync_b <= 1'b0;
    end
    else
    begin
      wait_sync_a <= ext_wait_in;
      wait_sync_b <= wait_sync_a;
    end
  end
  always @(posedge ref_clk_in)
  begin
    if (state == A_IDLE && busy && hit_ram && write)
      ram[addr[8:1]] <= wdata;
  end
  // Access sequencer.
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= A_IDLE;
      fault <= 1'b0;
      rdata <= 16'h0000;
      core_rdata_out <= 16'h0000;
      dma_rdata_out <= 16'h0000;
      win_sel_out <= 1'b0;
      win_write_out <= 1'b0;
      win_offset_out <= 12'h000;
      win_wdata_out <= 16'h0000;
      ext_addr_out <= {`MIFDEC_EXT_ADDR_HIGH{1'b0}};
      ext_data_out <= 16'h0000;
      ext_data_oe_n_out <= 1'b1;
    end
    else
    begin
      case (state)
        A_IDLE:
        begin
          if (busy)
          begin
            fault <= 1'b0;
            if (hit_win)
            begin
              state <= A_LOCAL;
              win_sel_out <= 1'b1;
              win_write_out <= write;
              win_offset_out <= addr[11:0];
              win_wdata_out <= wdata;
            end
            else if (hit_ram)
            begin
              state <= A_LOCAL;
              rdata <= ram[addr[8:1]];
            end
            else if (ext_off)
            begin
              state <= A_DONE;
              fault <= 1'b1;
            end
            else
            begin
              state <= A_EXT;
              ext_addr_out <= addr[`MIFDEC_EXT_ADDR_HIGH:1];
              ext_data_out <= wdata;
              ext_data_oe_n_out <= !write;
            end
          end
        end
        A_LOCAL:
        begin
          if (win_sel_out)
            rdata <= win_rdata_in;
          win_sel_out <= 1'b0;
          win_write_out <= 1'b0;
          state <= A_DONE;
        end
        A_EXT:
        begin
          // Read data is only valid while the read strobe is low, so it is sampled there.
          if (!ext_rd_n_out)
            rdata <= ext_data_in;
          if (ext_done)
          begin
            ext_data_oe_n_out <= 1'b1;
            state <= A_DONE;
          end
        end
        A_DONE:
        begin
          if (core_gnt)
            core_rdata_out <= rdata;
          if (dma_gnt)
            dma_rdata_out <= rdata;
          state <= A_IDLE;
        end
        default:
          state <= A_IDLE;
      endcase
    end
  end
endmodule // mifdec_top

// ==== bench/mifdec_monitor.sv ====
// Port checker for the memory interface decode and arbitration block.
// Assumes it is bound to mifdec_top and sees that module's ports only.
module mifdec_monitor (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Requests and answers
  input wire logic core_burst_in,
  input wire logic [23:0] core_addr_in,
  input wire logic core_done_out,
  input wire logic core_fault_out,
  input wire logic dma_done_out,
  // Special function register port
  input wire logic sfr_wr_in,
  input wire logic [11:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  // Window and external bus
  input wire logic win_sel_out,
  input wire logic [11:0] win_offset_out,
  input wire logic win_obj_out,
  input wire logic ext_ale_out,
  input wire logic ext_rd_n_out,
  input wire logic ext_wr_n_out,
  input wire logic ext_data_oe_n_out
);
  logic [7:0] wbh;
  logic [7:0] wbl;
  logic [7:0] ctl;
  logic lock;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Shadow copies let the properties name the decode base without seeing the body.
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wbh <= 8'h0F;
      wbl <= 8'hF0;
      ctl <= 8'h00;
      lock <= 1'b0;
    end
    else
    begin
      if (sfr_wr_in && sfr_addr_in == 12'h497)
        wbh <= sfr_wdata_in;
      if (sfr_wr_in && sfr_addr_in == 12'h496)
        wbl <= sfr_wdata_in;
      if (sfr_wr_in && sfr_addr_in == 12'h495)
        ctl <= sfr_wdata_in;
      if (core_done_out)
        lock <= core_burst_in;
    end
  end
  sequence s_ale;
    $rose(ext_ale_out);
  endsequence
  sequence s_strobe;
    !ext_rd_n_out || !ext_wr_n_out;
  endsequence
  a_window_enable_gate: assert property (win_sel_out |-> wbl[0])
    else $error("window strobe while window disabled");
  a_window_base_hit: assert property (win_sel_out |-> core_addr_in[23:12] == {wbh, wbl[7:4]})
    else $error("window strobe for an address outside the window");
  a_window_offset_copy: assert property (win_sel_out |-> win_offset_out == core_addr_in[11:0])
    else $error("window offset differs from low address bits");
  a_object_range_flag: assert property (win_obj_out == (win_sel_out && win_offset_out <= 12'h1FF))
    else $error("object register flag wrong for offset");
  a_ext_disable_quiet: assert property (s_ale |-> !ctl[3])
    else $error("external cycle while external access disabled");
  a_fault_on_disable: assert property (core_fault_out |-> core_done_out && ctl[3])
    else $error("fault without disabled external access");
  a_single_owner: assert property (!(core_done_out && dma_done_out))
    else $error("both requesters completed together");
  a_burst_lock_hold: assert property (dma_done_out |-> !lock)
    else $error("dma access inside a core burst");
  a_read_bus_released: assert property (!ext_rd_n_out |-> ext_data_oe_n_out)
    else $error("data bus driven during a read");
  a_strobe_after_latch: assert property (s_ale |-> ##[1:8] s_strobe)
    else $error("no strobe after address latch");
endmodule // mifdec_monitor

bind mifdec_top mifdec_monitor u_monitor (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .core_burst_in(core_burst_in),
  .core_addr_in(core_addr_in), .core_done_out(core_done_out),
  .core_fault_out(core_fault_out), .dma_done_out(dma_done_out), .sfr_wr_in(sfr_wr_in),
  .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .win_sel_out(win_sel_out),
  .win_offset_out(win_offset_out), .win_obj_out(win_obj_out), .ext_ale_out(ext_ale_out),
  .ext_rd_n_out(ext_rd_n_out), .ext_wr_n_out(ext_wr_n_out),
  .ext_data_oe_n_out(ext_data_oe_n_out)
);

// ==== bench/mifdec_ext_mem.sv ====
// External 16-bit memory model for the memory interface bench.
// Assumes active-low strobes; only address bits 8:1 select a word.
module mifdec_ext_mem (
  // Clock and mode
  input wire logic clk_in,
  input wire logic slow_in,
  // Memory bus
  input wire logic [19:1] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic oe_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  output logic [15:0] rdata_out,
  output logic wait_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  int n = 0;
  // A released bus shows the inverse of its last value, so a late sample cannot match.
  assign rdata_out = !rd_n_in ? mem[addr_in[8:1]] : ~last;
  assign wait_out = slow_in && (!rd_n_in || !wr_n_in) && n < 2;
  always @(posedge clk_in)
  begin
    n <= (!rd_n_in || !wr_n_in) ? n + 1 : 0;
    if (!rd_n_in)
      last <= mem[addr_in[8:1]];
    if (!wr_n_in && !oe_n_in)
      mem[addr_in[8:1]] <= wdata_in;
  end
endmodule // mifdec_ext_mem

// ==== bench/mifdec_tb_top.sv ====
// Self-checking bench for the memory interface decode and arbitration block.
// Assumes mifdec_top, its checker and the external memory model are compiled.
module mifdec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] W = 24'h123000;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] req = 2'b00;
  logic [1:0] wr = 2'b00;
  logic [1:0] burst = 2'b00;
  logic [15:0] wd [0:1] = '{16'h0000, 16'h0000};
  logic [23:0] caddr = 24'h000000;
  logic [15:0] daddr = 16'h0000;
  logic swr = 1'b0;
  logic [11:0] saddr = 12'h000;
  logic [7:0] sdat = 8'h00;
  logic slow = 1'b0;
  wire [1:0] done;
  wire [1:0] fault;
  wire [15:0] crd, drd, xin, xout;
  wire [7:0] srd;
  wire [19:1] xaddr;
  wire xoe_n, ale, rd_n, wr_n, xwait, wsel;
  wire wwr;
  wire [15:0] wwd;
  logic [15:0] wseen = 16'h0000;
  logic [15:0] got [0:1];
  logic flt [0:1];
  bit order [$];
  int ale_n = 0;
  int win_n = 0;
  int rdlow_n = 0;
  int mismatches = 0;
  int compares = 0;
  mifdec_top dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .core_req_in(req[0]),
    .core_burst_in(burst[0]), .core_write_in(wr[0]), .core_addr_in(caddr),
    .core_wdata_in(wd[0]), .core_done_out(done[0]), .core_rdata_out(crd),
    .core_fault_out(fault[0]), .dma_req_in(req[1]), .dma_write_in(wr[1]),
    .dma_addr_in(daddr), .dma_wdata_in(wd[1]), .dma_done_out(done[1]),
    .dma_rdata_out(drd), .dma_fault_out(fault[1]), .sfr_wr_in(swr), .sfr_addr_in(saddr),
    .sfr_wdata_in(sdat), .sfr_rdata_out(srd), .win_sel_out(wsel), .win_write_out(wwr),
    .win_offset_out(), .win_wdata_out(wwd), .win_obj_out(), .win_rdata_in(16'hC35A),
    .ext_addr_out(xaddr), .ext_data_in(xin), .ext_data_out(xout),
    .ext_data_oe_n_out(xoe_n), .ext_ale_out(ale), .ext_rd_n_out(rd_n),
    .ext_wr_n_out(wr_n), .ext_wait_in(xwait)
  );
  mifdec_ext_mem u_mem (
    .clk_in(ref_clk_in), .slow_in(slow), .addr_in(xaddr), .wdata_in(xout),
    .oe_n_in(xoe_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .rdata_out(xin), .wait_out(xwait)
  );
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
  begin
    if (ale === 1'b1)
      ale_n++;
    if (wsel === 1'b1)
      win_n++;
    if (wsel === 1'b1 && wwr === 1'b1)
      wseen = wwd;
    if (rd_n === 1'b0)
      rdlow_n++;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(input int i, input logic w, input logic b, input logic [23:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    req[i] <= 1'b1;
    wr[i] <= w;
    burst[i] <= b;
    wd[i] <= d;
    if (i == 0)
      caddr <= a;
    else
      daddr <= a[15:0];
    do
      @(posedge ref_clk_in);
    while (done[i] !== 1'b1 && n++ < 200);
    chk({15'h0, done[i]}, 16'h0001);
    flt[i] = fault[i];
    req[i] <= 1'b0;
    @(posedge ref_clk_in);
    got[i] = (i == 0) ? crd : drd;
    order.push_back(i[0]);
  endtask
  task automatic sfr_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    swr <= 1'b1;
    saddr <= a;
    sdat <= d;
    @(posedge ref_clk_in);
    swr <= 1'b0;
  endtask
  task automatic sfr_check(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    saddr <= a;
    @(negedge ref_clk_in);
    chk({8'h00, srd}, {8'h00, e});
  endtask
  task automatic t_reset();
    sfr_check(12'h495, 8'h00);
    sfr_check(12'h496, 8'hF0);
    sfr_check(12'h497, 8'h0F);
    sfr_check(12'h400, 8'h00);
  endtask
  task automatic t_window();
    int a0;
    int w0;
    a0 = ale_n;
    w0 = win_n;
    acc(0, 1'b0, 1'b0, 24'h0FF010, 16'h0000);
    chk({15'h0, ale_n != a0 && win_n == w0}, 16'h0001);
    sfr_write(12'h497, 8'h12);
    sfr_write(12'h496, 8'h31);
    sfr_check(12'h497, 8'h12);
    acc(0, 1'b0, 1'b0, W + 24'h040, 16'h0000);
    chk(got[0], 16'hC35A);
    acc(0, 1'b0, 1'b0, W + 24'h210, 16'h0000);
    chk({15'h0, win_n == w0 + 2}, 16'h0001);
  endtask
  task automatic t_external_access_disable();
    int a0;
    sfr_write(12'h495, 8'h08);
    sfr_check(12'h495, 8'h08);
    a0 = ale_n;
    acc(0, 1'b0, 1'b0, 24'h000400, 16'h0000);
    chk({15'h0, flt[0]}, 16'h0001);
    chk({15'h0, ale_n == a0}, 16'h0001);
    sfr_write(12'h495, 8'h00);
  endtask
  task automatic t_ext();
    int r0;
    acc(0, 1'b1, 1'b0, W + 24'h291, 16'h0500);
    chk(wseen, 16'h0500);
    acc(1, 1'b1, 1'b0, 24'h000120, 16'hBEEF);
    slow <= 1'b1;
    r0 = rdlow_n;
    acc(0, 1'b0, 1'b0, 24'h050120, 16'h0000);
    chk(got[0], 16'hBEEF);
    chk({15'h0, rdlow_n - r0 > 4}, 16'h0001);
    sfr_write(12'h495, 8'h10);
    r0 = rdlow_n;
    acc(1, 1'b0, 1'b0, 24'h000120, 16'h0000);
    chk(got[1], 16'hBEEF);
    chk(16'(rdlow_n - r0), 16'h0004);
    sfr_write(12'h495, 8'h00);
    slow <= 1'b0;
  endtask
  task automatic t_buffer_ram();
    int a0;
    acc(0, 1'b1, 1'b0, W + 24'h290, 16'h00FF);
    a0 = ale_n;
    acc(0, 1'b1, 1'b0, 24'h05FE10, 16'h1234);
    acc(1, 1'b0, 1'b0, 24'h00FE10, 16'h0000);
    chk(got[1], 16'h1234);
    chk({15'h0, ale_n == a0}, 16'h0001);
  endtask
  task automatic t_arb();
    order.delete();
    fork
      begin
        acc(0, 1'b0, 1'b0, 24'h05FE10, 16'h0000);
        acc(0, 1'b0, 1'b0, 24'h05FE10, 16'h0000);
      end
      begin
        acc(1, 1'b0, 1'b0, 24'h00FE10, 16'h0000);
        acc(1, 1'b0, 1'b0, 24'h00FE10, 16'h0000);
      end
    join
    chk({13'h0, order[0] ^ order[1], order[1] ^ order[2], order[2] ^ order[3]}, 16'h0007);
    order.delete();
    fork
      begin
        acc(0, 1'b0, 1'b1, 24'h05FE10, 16'h0000);
        acc(0, 1'b0, 1'b0, 24'h05FE10, 16'h0000);
      end
      begin
        @(posedge ref_clk_in);
        acc(1, 1'b0, 1'b0, 24'h00FE10, 16'h0000);
      end
    join
    chk({13'h0, order[0], order[1], order[2]}, 16'h0001);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_window();
    t_external_access_disable();
    t_ext();
    t_buffer_ram();
    t_arb();
    summarize();
  end
  // The whole run needs a few hundred cycles; this leaves ample margin.
  initial
  begin
    #200us;
    mismatches++;
    summarize();
  end
endmodule // mifdec_tb_top
